// File: i2c_master_model.sv
/*
 Behavioural two-wire bus master that drives the slave receiver.
 Assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
module i2c_master_model (
   input wire logic scl_w,
   input wire logic sda_w,
   output logic scl_oe,
   output logic sda_oe
);
   localparam time HALF = 100ns;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // Release SCL and wait out any stretch by the slave
   task automatic rise;
      scl_oe = 1'b0;
      wait (scl_w === 1'b1);
      #HALF;
   endtask : rise
   task automatic start_cond;
      sda_oe = 1'b0;
      rise();
      sda_oe = 1'b1;
      #HALF;
      scl_oe = 1'b1;
   endtask : start_cond
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #(HALF / 2);
         sda_oe = ~b[i];
         #(HALF / 2);
         rise();
         scl_oe = 1'b1;
      end
      #(HALF / 2);
      sda_oe = 1'b0;
      #(HALF / 2);
      scl_oe = 1'b0;
      wait (scl_w === 1'b1);
      #(HALF / 2);
      ack = sda_w;
      #(HALF / 2);
      scl_oe = 1'b1;
   endtask : send_byte
   task automatic stop_cond;
      #(HALF / 2);
      sda_oe = 1'b1;
      #(HALF / 2);
      rise();
      sda_oe = 1'b0;
      #HALF;
   endtask : stop_cond
endmodule : i2c_master_model

// File: i2c_rx_pkg.sv
/*
 Constants, register map and carrier types of the two-wire slave receiver
 and master Start generator. Assumes an AHB-Lite register bus, 32-bit data.
*/
package i2c_rx_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CTRL2_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] SBUF_OFS = 8'h0c;
   localparam logic [7:0] ADDR_OFS = 8'h10;
   localparam logic [7:0] BAUD_OFS = 8'h14;
   // Control register bits
   localparam int CB_EN = 0;
   localparam int CB_START_IE = 1;
   localparam int CB_STOP_IE = 2;
   localparam int CB_STRETCH = 3;
   localparam int CB_ADDRESS_HOLD_ENABLE = 4;
   localparam int CB_DATA_HOLD_ENABLE = 5;
   localparam int CB_MASTER = 6;
   // Second control register bits
   localparam int C2B_START = 0;
   localparam int C2B_ACK_DATA_VALUE = 5;
   localparam int C2B_CKP = 6;
   localparam logic [7:0] C2_LOCK_MASK = 8'h1f;
   // Status register bits
   localparam int SB_START = 0;
   localparam int SB_STOP = 1;
   localparam int SB_BF = 2;
   localparam int SB_IRQ = 3;
   localparam int SB_ACK_TIME_STATUS = 4;
   localparam int SB_WRITE_COLLISION_FLAG = 5;
   localparam int SB_BCOL = 6;
   localparam logic [7:0] STAT_W1C_MASK = 8'h68;
   // Reset values, then bits per byte
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h40;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h04;
   localparam logic [3:0] BYTE_BITS = 4'd8;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2c_lines_t;

   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } i2c_drive_t;

   typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_DATA, SL_ACK, SL_IGNORE} slave_state_t;
   typedef enum logic [1:0] {MS_IDLE, MS_SETUP, MS_HOLD} mstart_state_t;
endpackage : i2c_rx_pkg

// File: i2c_slave_rx.sv
/*
 Two-wire slave receiver (7-bit address, optional address/data hold and
 clock stretching), shift-buffer write guard and master Start generator,
 behind an AHB-Lite register slave. Assumes the pins are open drain with
 external pull-ups and that the pin inputs are asynchronous to clk.
*/
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module i2c_slave_rx #(
   parameter int BAUD_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire i2c_rx_pkg::i2c_lines_t lines_in,
   output i2c_rx_pkg::i2c_drive_t drive
);
   import i2c_rx_pkg::*;

   if (BAUD_W != 8) begin : g_check
      $error("baud reload is eight bits wide");
   end

   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic hresp_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl2_reg;
   logic [7:0] stat_reg;
   logic [7:0] own_addr_reg;
   logic [7:0] baud_reload_value;
   logic [7:0] shift_buffer;
   logic [7:0] tx_buf_reg;
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic scl_reg;
   logic sda_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   slave_state_t sl_state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] rx_shift_reg;
   logic is_addr_reg;
   logic hold_reg;
   logic stretch_reg;
   mstart_state_t ms_state_reg;
   logic [BAUD_W-1:0] baud_cnt_reg;
   logic master_sda_low_reg;
   i2c_drive_t drive_reg;
   logic [7:0] rd_data;

   wire addr_ok = hsel & hready & htrans[1];
   wire [7:0] wr_data = hwdata[7:0];
   wire ctrl_wr = wr_pend_reg && wr_addr_reg == CTRL_OFS;
   wire ctrl2_wr = wr_pend_reg && wr_addr_reg == CTRL2_OFS;
   wire stat_wr = wr_pend_reg && wr_addr_reg == STAT_OFS;
   wire sbuf_wr = wr_pend_reg && wr_addr_reg == SBUF_OFS;
   wire sbuf_rd = addr_ok && !hwrite && haddr[7:0] == SBUF_OFS;
   wire slave_on = ctrl_reg[CB_EN] && !ctrl_reg[CB_MASTER];
   wire scl_rise = scl_reg && !scl_prev_reg;
   wire scl_fall = !scl_reg && scl_prev_reg;
   wire start_det = slave_on && scl_reg && scl_prev_reg && !sda_reg && sda_prev_reg;
   wire stop_det = slave_on && scl_reg && scl_prev_reg && sda_reg && !sda_prev_reg;
   wire in_byte = sl_state_reg == SL_ADDR || sl_state_reg == SL_DATA;
   wire byte_done = slave_on && !start_det && !stop_det && in_byte && scl_fall
      && bit_cnt_reg == BYTE_BITS;
   wire addr_match = rx_shift_reg[7:1] == own_addr_reg[6:0] && !rx_shift_reg[0];
   wire byte_ok = byte_done && (!is_addr_reg || addr_match);
   wire hold_next = is_addr_reg ? ctrl_reg[CB_ADDRESS_HOLD_ENABLE] : ctrl_reg[CB_DATA_HOLD_ENABLE];
   wire ack_done = slave_on && !start_det && !stop_det && sl_state_reg == SL_ACK && scl_fall;
   wire nack_val = hold_reg & ctrl2_reg[C2B_ACK_DATA_VALUE];
   wire ms_start_req = ctrl_reg[CB_EN] && ctrl_reg[CB_MASTER] && ctrl2_reg[C2B_START];
   wire lines_high = scl_reg && sda_reg;
   wire ms_collide = (ms_state_reg == MS_IDLE && ms_start_req && !lines_high)
      || (ms_state_reg == MS_SETUP && (!scl_reg || (baud_cnt_reg == '0 && !sda_reg)));
   wire ms_formed = ms_state_reg == MS_SETUP && baud_cnt_reg == '0 && lines_high;
   wire ms_done = ms_state_reg == MS_HOLD && baud_cnt_reg == '0;
   wire ms_busy = ms_state_reg != MS_IDLE;
   wire busy = ms_busy || (sl_state_reg != SL_IDLE && sl_state_reg != SL_IGNORE);
   wire stretch_set = (byte_ok && hold_next)
      || (ack_done && !nack_val && ctrl_reg[CB_STRETCH]);

   // AHB-Lite slave, zero wait states, always OKAY
   always_comb begin
      unique case (haddr[7:0])
         CTRL_OFS: rd_data = ctrl_reg;
         CTRL2_OFS: rd_data = ctrl2_reg;
         STAT_OFS: rd_data = stat_reg;
         SBUF_OFS: rd_data = shift_buffer;
         ADDR_OFS: rd_data = own_addr_reg;
         BAUD_OFS: rd_data = baud_reload_value;
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         wr_pend_reg <= addr_ok && hwrite && haddr[31:8] == 24'h0 && haddr[1:0] == 2'b00;
         wr_addr_reg <= haddr[7:0];
         hrdata_reg <= (addr_ok && !hwrite) ? {24'h0, rd_data} : 32'h0;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= CTRL_RST;
         own_addr_reg <= ADDR_RST;
         baud_reload_value <= BAUD_RST;
      end else begin
         if (ctrl_wr) ctrl_reg <= wr_data;
         if (wr_pend_reg && wr_addr_reg == ADDR_OFS) own_addr_reg <= wr_data;
         if (wr_pend_reg && wr_addr_reg == BAUD_OFS) baud_reload_value <= wr_data;
      end
   end

   // Second control: low bits locked during Start, hardware clears win
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl2_reg <= CTRL2_RST;
      end else begin
         if (ctrl2_wr) begin
            if (ms_busy) begin
               ctrl2_reg <= (ctrl2_reg & C2_LOCK_MASK) | (wr_data & ~C2_LOCK_MASK);
            end else begin
               ctrl2_reg <= wr_data;
            end
         end
         if (stretch_set) ctrl2_reg[C2B_CKP] <= 1'b0;
         if (ms_done || ms_collide) ctrl2_reg[C2B_START] <= 1'b0;
      end
   end

   // Pin synchronisers; a change counts once stages two and three agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scl_sync_reg <= 3'b111;
         sda_sync_reg <= 3'b111;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], lines_in.scl};
         sda_sync_reg <= {sda_sync_reg[1:0], lines_in.sda};
         if (scl_sync_reg[2] == scl_sync_reg[1]) scl_reg <= scl_sync_reg[2];
         if (sda_sync_reg[2] == sda_sync_reg[1]) sda_reg <= sda_sync_reg[2];
         scl_prev_reg <= scl_reg;
         sda_prev_reg <= sda_reg;
      end
   end

   // Slave receive sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sl_state_reg <= SL_IDLE;
         bit_cnt_reg <= 4'd0;
         rx_shift_reg <= 8'h00;
         is_addr_reg <= 1'b0;
         hold_reg <= 1'b0;
      end else if (!slave_on || stop_det) begin
         sl_state_reg <= SL_IDLE;
      end else if (start_det) begin
         sl_state_reg <= SL_ADDR;
         bit_cnt_reg <= 4'd0;
         is_addr_reg <= 1'b1;
      end else begin
         unique case (sl_state_reg)
            SL_ADDR, SL_DATA: begin
               if (scl_rise && bit_cnt_reg != BYTE_BITS) begin
                  rx_shift_reg <= {rx_shift_reg[6:0], sda_reg};
                  bit_cnt_reg <= bit_cnt_reg + 4'd1;
               end
               if (byte_ok) begin
                  sl_state_reg <= SL_ACK;
                  hold_reg <= hold_next;
               end else if (byte_done) begin
                  sl_state_reg <= SL_IGNORE;
               end
            end
            SL_ACK: begin
               if (ack_done) begin
                  sl_state_reg <= nack_val ? SL_IDLE : SL_DATA;
                  bit_cnt_reg <= 4'd0;
                  is_addr_reg <= 1'b0;
               end
            end
            SL_IDLE, SL_IGNORE: sl_state_reg <= sl_state_reg;
         endcase
      end
   end

   // Clock stretch until software sets clock release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stretch_reg <= 1'b0;
      end else if (!slave_on || start_det || stop_det) begin
         stretch_reg <= 1'b0;
      end else if (stretch_set) begin
         stretch_reg <= 1'b1;
      end else if (ctrl2_reg[C2B_CKP]) begin
         stretch_reg <= 1'b0;
      end
   end

   // Received byte lands in the shift buffer; guarded software writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shift_buffer <= 8'h00;
         tx_buf_reg <= 8'h00;
      end else begin
         if (byte_ok) shift_buffer <= rx_shift_reg;
         if (sbuf_wr && !busy) tx_buf_reg <= wr_data;
      end
   end

   // Master Start generator
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ms_state_reg <= MS_IDLE;
         baud_cnt_reg <= '0;
         master_sda_low_reg <= 1'b0;
      end else begin
         if (!ctrl_reg[CB_MASTER]) master_sda_low_reg <= 1'b0;
         unique case (ms_state_reg)
            MS_IDLE: begin
               if (ms_start_req && lines_high) begin
                  baud_cnt_reg <= baud_reload_value;
                  ms_state_reg <= MS_SETUP;
               end
            end
            MS_SETUP: begin
               if (ms_collide) begin
                  ms_state_reg <= MS_IDLE;
               end else if (ms_formed) begin
                  master_sda_low_reg <= 1'b1;
                  baud_cnt_reg <= baud_reload_value;
                  ms_state_reg <= MS_HOLD;
               end else begin
                  baud_cnt_reg <= baud_cnt_reg - BAUD_W'(1);
               end
            end
            MS_HOLD: begin
               if (ms_done) begin
                  ms_state_reg <= MS_IDLE;
               end else begin
                  baud_cnt_reg <= baud_cnt_reg - BAUD_W'(1);
               end
            end
            default: ms_state_reg <= MS_IDLE;
         endcase
      end
   end

   // Status bits; hardware set wins over software clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stat_reg <= STAT_RST;
      end else begin
         if (stat_wr) stat_reg <= stat_reg & ~(wr_data & STAT_W1C_MASK);
         if (start_det || ms_formed) begin
            stat_reg[SB_START] <= 1'b1;
            stat_reg[SB_STOP] <= 1'b0;
         end
         if (stop_det) begin
            stat_reg[SB_STOP] <= 1'b1;
            stat_reg[SB_START] <= 1'b0;
         end
         if ((start_det && ctrl_reg[CB_START_IE]) || (stop_det && ctrl_reg[CB_STOP_IE])
               || byte_ok || (ack_done && hold_reg && !nack_val)) begin
            stat_reg[SB_IRQ] <= 1'b1;
         end
         if (byte_ok) begin
            stat_reg[SB_ACK_TIME_STATUS] <= 1'b1;
         end else if (ack_done || sl_state_reg != SL_ACK) begin
            stat_reg[SB_ACK_TIME_STATUS] <= 1'b0;
         end
         if (byte_ok) begin
            stat_reg[SB_BF] <= 1'b1;
         end else if (sbuf_rd) begin
            stat_reg[SB_BF] <= 1'b0;
         end
         if (sbuf_wr && busy) stat_reg[SB_WRITE_COLLISION_FLAG] <= 1'b1;
         if (ms_collide) stat_reg[SB_BCOL] <= 1'b1;
      end
   end

   // Open-drain drivers: only the enables move, the level is always low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drive_reg <= '0;
      end else begin
         drive_reg.scl_o <= 1'b0;
         drive_reg.sda_o <= 1'b0;
         drive_reg.scl_oe <= stretch_reg;
         drive_reg.sda_oe <= (sl_state_reg == SL_ACK && !nack_val)
            || master_sda_low_reg;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign drive = drive_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_start_irq;
      start_det && ctrl_reg[CB_START_IE] |=> stat_reg[SB_IRQ] && stat_reg[SB_START];
   endproperty
   a_start_irq: assert property (p_start_irq) else $error("start irq missing");

   property p_ack_drive;
      byte_ok && !hold_next && !master_sda_low_reg |=> ##1 drive_reg.sda_oe;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

   property p_bf_clear;
      sbuf_rd && !byte_ok |=> !stat_reg[SB_BF];
   endproperty
   a_bf_clear: assert property (p_bf_clear) else $error("buffer full stuck");

   property p_stretch;
      stretch_reg && !ctrl2_reg[C2B_CKP] && slave_on |=> drive_reg.scl_oe;
   endproperty
   a_stretch: assert property (p_stretch) else $error("scl not stretched");

   property p_stop;
      stop_det |=> stat_reg[SB_STOP] && sl_state_reg == SL_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not handled");

   property p_hold;
      byte_ok && hold_next |=> !ctrl2_reg[C2B_CKP] && stat_reg[SB_IRQ] && stat_reg[SB_ACK_TIME_STATUS];
   endproperty
   a_hold: assert property (p_hold) else $error("hold event wrong");

   property p_nack;
      ack_done && nack_val |=> sl_state_reg == SL_IDLE ##1 !drive_reg.sda_oe;
   endproperty
   a_nack: assert property (p_nack) else $error("nack not ending");

   property p_write_collision_flag;
      sbuf_wr && busy |=> stat_reg[SB_WRITE_COLLISION_FLAG] && $stable(tx_buf_reg);
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("write collision missed");

   property p_lock;
      ctrl2_wr && ms_busy |=> ctrl2_reg[4:1] == $past(ctrl2_reg[4:1]);
   endproperty
   a_lock: assert property (p_lock) else $error("locked bits changed");

   property p_formed;
      ms_formed |=> master_sda_low_reg && stat_reg[SB_START] ##1 drive_reg.sda_oe;
   endproperty
   a_formed: assert property (p_formed) else $error("start not formed");

   property p_sen_clear;
      ms_done |=> !ctrl2_reg[C2B_START] && ms_state_reg == MS_IDLE;
   endproperty
   a_sen_clear: assert property (p_sen_clear) else $error("start enable kept");

   property p_bcol;
      ms_state_reg == MS_SETUP && !scl_reg |=> stat_reg[SB_BCOL] && ms_state_reg == MS_IDLE;
   endproperty
   a_bcol: assert property (p_bcol) else $error("collision missed");

   c_addr: cover property (byte_ok && is_addr_reg);
   c_hold_ack: cover property (ack_done && hold_reg && !nack_val);
   c_master_start: cover property (ms_done);
   c_write_collision_flag: cover property (sbuf_wr && busy);
endmodule : i2c_slave_rx

// File: i2c_slave_rx_and_master_start_bench.sv
/*
 Self-checking bench: AHB-Lite register tasks plus a bus master model.
 Assumes the receiver's register map and reset values from its package.
*/
`timescale 1ns/1ps
module i2c_slave_rx_and_master_start_bench;
   import i2c_rx_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   i2c_lines_t lines_in;
   i2c_drive_t drive;
   logic m_scl_oe;
   logic m_sda_oe;
   logic tb_scl_low = 1'b0;
   int miscompares = 0;
   int total_checks = 0;
   logic [31:0] rd;
   logic ack;
   always #5ns clk = ~clk;
   assign lines_in = '{scl: ~(drive.scl_oe | m_scl_oe | tb_scl_low),
      sda: ~(drive.sda_oe | m_sda_oe)};
   i2c_slave_rx DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .lines_in(lines_in), .drive(drive));
   i2c_master_model m (.scl_w(lines_in.scl), .sda_w(lines_in.sda),
      .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] wd);
      logic rdy;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin
         @(negedge clk);
         rdy = hreadyout;
         @(posedge clk);
      end while (rdy !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do begin
         @(negedge clk);
         rdy = hreadyout;
         rd = hrdata;
         @(posedge clk);
      end while (rdy !== 1'b1);
      hsel <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e);
      xfer(a, 1'b0, 8'h00);
      check(rd & {24'hffffff, msk}, {24'h0, e});
   endtask : rchk
   task automatic wait_stretch;
      int n;
      n = 0;
      while (drive.scl_oe !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, drive.scl_oe}, 32'h1);
   endtask : wait_stretch
   task automatic test_done;
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   initial begin
      #500us;
      miscompares++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rchk(CTRL2_OFS, 8'hff, CTRL2_RST);
      rchk(BAUD_OFS, 8'hff, BAUD_RST);
      wr(8'h18, 8'h5a);
      rchk(8'h18, 8'hff, 8'h00);
      $display("reset values done");
      wr(ADDR_OFS, 8'h5a);
      wr(CTRL_OFS, 8'h03);
      m.start_cond();
      rchk(STAT_OFS, 8'hff, 8'h09);
      wr(STAT_OFS, 8'h08);
      m.send_byte(8'hb4, ack);
      check({31'h0, ack}, 32'h0);
      rchk(STAT_OFS, 8'h0c, 8'h0c);
      rchk(SBUF_OFS, 8'hff, 8'hb4);
      rchk(STAT_OFS, 8'h04, 8'h00);
      wr(STAT_OFS, 8'h08);
      fork
         m.send_byte(8'h3c, ack);
         begin
            repeat (100) @(posedge clk);
            wr(SBUF_OFS, 8'hff);
         end
      join
      check({31'h0, ack}, 32'h0);
      rchk(STAT_OFS, 8'h2c, 8'h2c);
      rchk(SBUF_OFS, 8'hff, 8'h3c);
      wr(STAT_OFS, 8'h28);
      m.stop_cond();
      rchk(STAT_OFS, 8'h0a, 8'h02);
      m.start_cond();
      wr(STAT_OFS, 8'h08);
      m.send_byte(8'h44, ack);
      check({31'h0, ack}, 32'h1);
      rchk(STAT_OFS, 8'h0c, 8'h00);
      m.stop_cond();
      rchk(STAT_OFS, 8'h02, 8'h02);
      $display("plain receive done");
      wr(CTRL_OFS, 8'h09);
      m.start_cond();
      m.send_byte(8'hb4, ack);
      fork
         m.send_byte(8'h81, ack);
         begin
            wait_stretch();
            rchk(CTRL2_OFS, 8'h40, 8'h00);
            wr(STAT_OFS, 8'h08);
            wr(CTRL2_OFS, 8'h40);
         end
      join
      fork
         m.stop_cond();
         begin
            wait_stretch();
            rchk(SBUF_OFS, 8'hff, 8'h81);
            wr(CTRL2_OFS, 8'h40);
         end
      join
      check({31'h0, ack}, 32'h0);
      $display("stretch done");
      wr(CTRL_OFS, 8'h39);
      m.start_cond();
      wr(STAT_OFS, 8'h08);
      fork
         m.send_byte(8'hb4, ack);
         begin
            wait_stretch();
            rchk(STAT_OFS, 8'h18, 8'h18);
            rchk(CTRL2_OFS, 8'h40, 8'h00);
            wr(STAT_OFS, 8'h08);
            wr(CTRL2_OFS, 8'h40);
            repeat (60) @(posedge clk);
            rchk(STAT_OFS, 8'h08, 8'h08);
            wait_stretch();
            rchk(CTRL2_OFS, 8'h40, 8'h00);
            wr(CTRL2_OFS, 8'h40);
         end
      join
      check({31'h0, ack}, 32'h0);
      wr(STAT_OFS, 8'h08);
      fork
         m.send_byte(8'h55, ack);
         begin
            wait_stretch();
            rchk(SBUF_OFS, 8'hff, 8'h55);
            wr(STAT_OFS, 8'h08);
            wr(CTRL2_OFS, 8'h60);
            repeat (60) @(posedge clk);
            rchk(STAT_OFS, 8'h08, 8'h00);
         end
      join
      check({31'h0, ack}, 32'h1);
      m.stop_cond();
      $display("hold mode done");
      wr(CTRL_OFS, 8'h41);
      wr(BAUD_OFS, 8'h20);
      wr(CTRL2_OFS, 8'h41);
      wr(CTRL2_OFS, 8'h40);
      rchk(CTRL2_OFS, 8'h01, 8'h01);
      check({31'h0, drive.sda_oe}, 32'h0);
      repeat (40) @(posedge clk);
      check({31'h0, drive.sda_oe}, 32'h1);
      rchk(STAT_OFS, 8'h01, 8'h01);
      repeat (40) @(posedge clk);
      rchk(CTRL2_OFS, 8'h01, 8'h00);
      check({31'h0, drive.sda_oe}, 32'h1);
      wr(CTRL_OFS, 8'h01);
      $display("master start done");
      wr(CTRL_OFS, 8'h41);
      tb_scl_low <= 1'b1;
      repeat (5) @(posedge clk);
      wr(CTRL2_OFS, 8'h41);
      repeat (10) @(posedge clk);
      rchk(STAT_OFS, 8'h40, 8'h40);
      rchk(CTRL2_OFS, 8'h01, 8'h00);
      check({31'h0, drive.sda_oe}, 32'h0);
      tb_scl_low <= 1'b0;
      wr(STAT_OFS, 8'h40);
      rchk(STAT_OFS, 8'h40, 8'h00);
      repeat (5) @(posedge clk);
      wr(CTRL2_OFS, 8'h41);
      repeat (5) @(posedge clk);
      tb_scl_low <= 1'b1;
      repeat (10) @(posedge clk);
      rchk(STAT_OFS, 8'h40, 8'h40);
      rchk(CTRL2_OFS, 8'h01, 8'h00);
      check({31'h0, drive.sda_oe}, 32'h0);
      tb_scl_low <= 1'b0;
      $display("collision done");
      test_done();
   end
endmodule : i2c_slave_rx_and_master_start_bench
